// ===== fcs_map.svh
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// Width of the fault condition vector
`define FCS_WIDTH        16
// Reset value of the condition register
`define FCS_COND_RST     16'h0000
// Width of the decimal-digit answer (five digits cover 65535)
`define FCS_DIGITS       5
`define FCS_DIGIT_W      4
// Shift steps per conversion, one per cycle (answer valid 18 edges after the query edge)
`define FCS_CONV_CYCLES  16
`endif

// ===== fcs_pkg.sv
`include "fcs_map.svh"
package fcs_pkg;
    typedef logic [`FCS_WIDTH-1:0] fcs_vec_t;
    // Answer to a condition query: binary sum and its decimal digits
    typedef struct packed {
        logic                                   valid;
        fcs_vec_t                               value;
        logic [`FCS_DIGITS*`FCS_DIGIT_W-1:0]    bcd;
    } fcs_resp_t;
    typedef enum logic [2:0] {
        FCS_IDLE = 3'b001,
        FCS_CONV = 3'b010,
        FCS_DONE = 3'b100
    } fcs_state_t;
endpackage

// ===== fcs_bcd_conv.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcs_map.svh"
// Serial binary to decimal converter, one bit per cycle (double dabble)
module fcs_bcd_conv
    import fcs_pkg::*;
(
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst_n,
    input  wire logic                                   i_start,
    input  wire fcs_vec_t                               i_bin,
    output var  logic                                   o_done,
    output var  logic [`FCS_DIGITS*`FCS_DIGIT_W-1:0]    o_bcd
);
    localparam int BW = `FCS_DIGITS*`FCS_DIGIT_W;
    typedef struct packed {
        logic           busy;
        logic           done;
        logic [4:0]     cnt;
        fcs_vec_t       sh;
        logic [BW-1:0]  bcd;
    } fcs_conv_st_t;
    fcs_conv_st_t st_ff, nxt_st;

    // Add three to every digit above four before the shift
    function automatic logic [BW-1:0] fcs_adj(input logic [BW-1:0] v);
        logic [BW-1:0] r;
        r = v;
        for (int d = 0; d < `FCS_DIGITS; d++) begin
            if (r[d*4 +: 4] > 4'h4) begin
                r[d*4 +: 4] = r[d*4 +: 4] + 4'h3;
            end
        end
        return r;
    endfunction

    // Step control and shift
    always_comb begin
        logic [BW-1:0] a;
        a = fcs_adj(st_ff.bcd);
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (i_start) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt = 5'h00;
            nxt_st.sh = i_bin;
            nxt_st.bcd = '0;
        end else if (st_ff.busy) begin
            nxt_st.bcd = {a[BW-2:0], st_ff.sh[`FCS_WIDTH-1]};
            nxt_st.sh = {st_ff.sh[`FCS_WIDTH-2:0], 1'b0};
            nxt_st.cnt = st_ff.cnt + 5'h01;
            if (st_ff.cnt == 5'(`FCS_CONV_CYCLES - 1)) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_done = st_ff.done;
    assign o_bcd  = st_ff.bcd;
endmodule
`default_nettype wire

// ===== fcs_fault_cond.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcs_map.svh"
module fcs_fault_cond
    import fcs_pkg::*;
#(
    parameter fcs_vec_t USED_MASK = 16'hFFFF
)
(
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire fcs_vec_t   i_fault_cond,
    input  wire logic       i_protocol_reset,
    input  wire logic       i_query_instrument_fault_condition,
    output var  fcs_vec_t   o_cond,
    output var  logic       o_query_busy,
    output var  fcs_resp_t  o_resp
);
    // Query timing, counted in rising edges from the one that takes the query:
    //   edge 0   query taken, register snapshot into the answer, busy rises
    //   edge 1   converter loads the snapshot
    //   edge 2   first of sixteen shift steps
    //   edge 17  last shift step, converter reports done
    //   edge 18  decimal digits land and the answer strobe rises
    //   edge 19  strobe falls, busy falls, a new query may follow
    // The answer value and digits then hold until the next query is taken.

    // Limitations worth knowing:
    //   - condition inputs are taken as synchronous to the core clock; a raw
    //     asynchronous fault line needs its own synchroniser upstream
    //   - a condition that lasts less than one clock period may never show
    //   - the answer snapshot is the register at the query edge, which is the
    //     condition inputs one edge earlier
    //   - which bits exist is fixed at build time by USED_MASK

    // Reset behaviour: while the pin is low every output is low and busy is
    // clear. After release the register follows its inputs from the third
    // rising edge, and the first query may be taken on that same edge.

    // Width of the decimal answer field
    localparam int BCD_W = `FCS_DIGITS*`FCS_DIGIT_W;

    // All registered state except the reset synchroniser, which runs from the
    // raw reset and so cannot share a register with the logic it releases
    typedef struct packed {
        fcs_state_t  state; // Query sequencer
        fcs_vec_t    cond;
        logic        start; // One-cycle kick to the converter
        logic        busy;
        fcs_resp_t   resp;  // Answer held for the host
    } fcs_top_st_t;
    fcs_top_st_t      st_ff;
    fcs_top_st_t      nxt_st;

    // Reset synchroniser and the released copy that the logic uses
    logic [1:0]       rst_sync_ff;
    logic             rst_n;

    // Converter handshake
    logic             conv_done;
    logic [BCD_W-1:0] conv_bcd;

    // Query acceptance
    logic             query_take;

    // Keep only implemented bits, so an unimplemented one can never read one;
    // used by the live copy and the protocol reset path alike
    function automatic fcs_vec_t fcs_live(input fcs_vec_t raw);
        return raw & USED_MASK;
    endfunction

    // The sequencer is busy whenever it is not waiting for a query
    function automatic logic fcs_busy_of(input fcs_state_t s);
        return (s != FCS_IDLE);
    endfunction

    // Reset release through two flops. The raw reset asserts at once, but its
    // release is retimed, so no flop behind it sees the edge near the clock.
    // Cost: the block stays in reset for two edges after the pin rises.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // A query counts only while idle. One that arrives while busy is dropped,
    // not queued; the host must watch the busy flag before asking again.
    assign query_take = i_query_instrument_fault_condition & ~st_ff.busy;

    // Condition mirror and query sequencing
    always_comb begin
        // Hold everything by default; strobes fall back to idle
        nxt_st            = st_ff;
        nxt_st.start      = 1'b0;
        nxt_st.resp.valid = 1'b0;

        // Live copy with no hold term, so a vanished condition drops next edge.
        // Nothing here looks at the query, so a read cannot disturb the bits.
        nxt_st.cond = fcs_live(i_fault_cond);

        // After a protocol reset the register holds only conditions still
        // present; since nothing is latched the live copy already is that value
        if (i_protocol_reset) begin
            nxt_st.cond = fcs_live(i_fault_cond);
        end

        // Query sequencer
        case (st_ff.state)
            FCS_IDLE: begin
                if (query_take) begin
                    // Snapshot only; the condition bits are not touched by a read
                    nxt_st.resp.value = st_ff.cond;
                    nxt_st.start      = 1'b1;
                    nxt_st.state      = FCS_CONV;
                end
            end
            FCS_CONV: begin
                // The snapshot stays put while the converter works on it
                if (conv_done) begin
                    nxt_st.resp.bcd   = conv_bcd;
                    nxt_st.resp.valid = 1'b1;
                    nxt_st.state      = FCS_DONE;
                end
            end
            FCS_DONE: begin
                // One spare cycle, so the strobe has ended before a new query
                nxt_st.state = FCS_IDLE;
            end
            default: begin
                // An illegal code heads back to idle rather than locking up
                nxt_st.state = FCS_IDLE;
            end
        endcase

        // Busy is computed from the next state, so the pin needs no decode
        nxt_st.busy = fcs_busy_of(nxt_st.state);
    end

    // State register; no path from the host writes the condition field
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.state <= FCS_IDLE;
            st_ff.cond  <= `FCS_COND_RST;
            st_ff.start <= 1'b0;
            st_ff.busy  <= 1'b0;
            st_ff.resp  <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Decimal converter; it reads the held snapshot, never the live bits
    fcs_bcd_conv u_conv (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_n),
        .i_start (st_ff.start),
        .i_bin   (st_ff.resp.value),
        .o_done  (conv_done),
        .o_bcd   (conv_bcd)
    );

    // Every output is a flop; no logic stands between register and pin
    assign o_cond       = st_ff.cond;
    assign o_query_busy = st_ff.busy;
    assign o_resp       = st_ff.resp;
endmodule
`default_nettype wire

// ===== fcs_fault_cond_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_fault_cond_sva
    import fcs_pkg::*;
#(
    parameter fcs_vec_t USED_MASK = 16'hFFFF
)
(
    input  wire logic      i_core_clk,
    input  wire logic      i_arst_n,
    input  wire fcs_vec_t  i_fault_cond,
    input  wire logic      i_protocol_reset,
    input  wire logic      i_query_instrument_fault_condition,
    input  wire fcs_vec_t  o_cond,
    input  wire logic      o_query_busy,
    input  wire fcs_resp_t o_resp
);
    logic [1:0] up_ff;
    fcs_vec_t   v;
    wire        rdy = (up_ff == 2'h3);
    wire        qry = i_query_instrument_fault_condition && !o_query_busy && rdy;
    assign v = o_resp.value;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // Skip the edges of the two-flop reset release
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) up_ff <= 2'h0;
        else if (!rdy) up_ff <= up_ff + 2'h1;
    end
    cond_track_a: assert property (rdy |-> o_cond == ($past(i_fault_cond) & USED_MASK))
        else $error("condition not followed");
    bit_clear_a: assert property (rdy && i_fault_cond == 16'h0 |=> o_cond == 16'h0)
        else $error("bit kept after condition left");
    reset_keep_a: assert property (rdy && i_protocol_reset |=>
        o_cond == ($past(i_fault_cond) & USED_MASK))
        else $error("protocol reset lost a live bit");
    query_keep_a: assert property (qry |=> o_cond == ($past(i_fault_cond) & USED_MASK))
        else $error("query disturbed the register");
    static_hold_a: assert property (rdy && $stable(i_fault_cond) |=> $stable(o_cond))
        else $error("register changed on its own");
    unused_zero_a: assert property ((o_cond & ~USED_MASK) == 16'h0)
        else $error("unused bit set");
    ans_time_a: assert property (qry |-> ##19 o_resp.valid)
        else $error("answer late");
    busy_span_a: assert property (qry |=> o_query_busy ##18
        o_query_busy ##1 !o_query_busy)
        else $error("busy span wrong");
    snap_value_a: assert property (qry |=> o_resp.value == $past(o_cond))
        else $error("answer not the register at the query");
    ans_sum_a: assert property (o_resp.valid |-> o_resp.bcd == {4'(v / 10000),
        4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)})
        else $error("decimal sum wrong");
endmodule
bind fcs_fault_cond fcs_fault_cond_sva #(.USED_MASK(USED_MASK)) sva (.i_core_clk, .i_arst_n,
    .i_fault_cond, .i_protocol_reset, .i_query_instrument_fault_condition, .o_cond,
    .o_query_busy, .o_resp);
`default_nettype wire

// ===== fcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host issuing one-cycle queries, never while an answer is pending
module fcs_host_model (
    input  wire logic i_clk,
    input  wire logic i_busy,
    input  wire logic i_go,
    output var  logic o_query
);
    // Falling edge keeps the request settled at the sampling edge
    always @(negedge i_clk) o_query <= i_go && !i_busy && !o_query;
endmodule
`default_nettype wire

// ===== fcs_fault_cond_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fcs_fault_cond_tb;
    import fcs_pkg::*;
    localparam fcs_vec_t MASK = 16'h7FFF; // Top bit unused
    logic      clk = 1'b0, rst_n = 1'b0, prst = 1'b0, go = 1'b0, qry, busy;
    fcs_vec_t  cond = 16'h0000, o_cond, exp_q[$];
    fcs_resp_t resp;
    logic [31:0] seed = 32'h63;
    int        errors = 0, n_tests = 0, cyc = 0;
    fcs_fault_cond #(.USED_MASK(MASK)) dut (.i_core_clk(clk), .i_arst_n(rst_n),
        .i_fault_cond(cond), .i_protocol_reset(prst),
        .i_query_instrument_fault_condition(qry), .o_cond(o_cond),
        .o_query_busy(busy), .o_resp(resp));
    fcs_host_model host (.i_clk(clk), .i_busy(busy), .i_go(go), .o_query(qry));
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [35:0] ans(input fcs_vec_t v);
        return {v, 4'(v / 10000), 4'(v / 1000 % 10), 4'(v / 100 % 10),
            4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    task automatic chk_resp(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: answer %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_cond(input fcs_vec_t got, input fcs_vec_t exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: register %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // A stuck conversion ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            stop_test();
        end
    end
    // Each answer pulse retires the oldest snapshot
    always @(negedge clk) begin
        if (resp.valid === 1'b1) chk_resp({resp.value, resp.bcd}, ans(exp_q.pop_front()));
    end
    initial begin
        fcs_vec_t v;
        repeat (16) @(negedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i == 2) ? 16'h0028 : 16'(rnd());
            cond <= v;
            @(negedge clk);
            go <= 1'b1;
            exp_q.push_back(v & MASK);
            @(negedge clk);
            go <= 1'b0;
            repeat (2) @(negedge clk);
            // Conditions move during conversion; the snapshot must not
            repeat (12) begin
                v = 16'(rnd());
                cond <= v;
                prst <= v[0] & ~prst;
                @(negedge clk);
                chk_cond(o_cond, v & MASK);
            end
            prst <= 1'b0;
            while (busy !== 1'b0) @(negedge clk);
        end
        repeat (3) @(negedge clk);
        // An answer that never came leaves its note behind
        if (exp_q.size() != 0) begin
            errors++;
            $display("mismatch at %0t: answer missing", $time);
        end
        stop_test();
    end
endmodule
`default_nettype wire
